// *** hcie_cpu_model.sv ***
// Behavioural processor on the shared bus: command strobe, then one data strobe.
// Assumes the block answers reads within a dozen cycles of rd_n falling.
`timescale 1ns/100ps
module hcie_cpu_model (
    input  wire logic        clk_sys,   // System clock
    input  wire logic [15:0] data_out,  // Read data from block
    input  wire logic        data_oe_n, // Block drives bus, low
    output logic             cs_n,      // Chip select, low
    output logic             cmd_wr_n,  // Command strobe, low
    output logic             wr_n,      // Write strobe, low
    output logic             rd_n,      // Read strobe, low
    output logic      [15:0] data_in,   // Bus data to block
    output logic             timeout    // A read got no answer
);
    // ==========================================================
    // Idle bus at time zero
    initial begin
        cs_n     = 1'b1;
        cmd_wr_n = 1'b1;
        wr_n     = 1'b1;
        rd_n     = 1'b1;
        data_in  = 16'h0000;
        timeout  = 1'b0;
    end

    // Set up data, pulse one strobe, then float the bus
    task automatic strobe(input logic [15:0] val, input bit is_cmd);
        data_in <= val;
        repeat (3) @(posedge clk_sys);
        if (is_cmd) cmd_wr_n <= 1'b0;
        else wr_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        cmd_wr_n <= 1'b1;
        wr_n     <= 1'b1;
        repeat (4) @(posedge clk_sys);
        // Released lines have no pull; show the inverse
        data_in <= ~val;
        @(posedge clk_sys);
    endtask

    task automatic write_reg(input logic [7:0] code, input logic [15:0] val);
        @(posedge clk_sys);
        cs_n <= 1'b0;
        strobe({8'h00, code}, 1'b1);
        strobe(val, 1'b0);
        cs_n <= 1'b1;
    endtask

    task automatic read_reg(input logic [7:0] code, output logic [15:0] val);
        int n;
        @(posedge clk_sys);
        cs_n <= 1'b0;
        strobe({8'h00, code}, 1'b1);
        rd_n <= 1'b0;
        n = 0;
        // Wait for the block to drive, bounded
        do begin
            @(posedge clk_sys);
            n++;
        end while (data_oe_n !== 1'b0 && n < 12);
        if (n >= 12) timeout <= 1'b1;
        val = data_out;
        repeat (2) @(posedge clk_sys);
        rd_n <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (data_oe_n !== 1'b1 && n < 12);
        cs_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask
endmodule

// *** hcie_gate.sv ***
// Masks status bits by enable bits and combines them under a global enable.
// Assumes status and enables are on clk_sys already.
`timescale 1ns/100ps
module hcie_gate (
    input  wire logic [15:0] status,     // Pending events
    input  wire logic [15:0] enable,     // Enable mask register
    input  wire logic        global_en,  // Global enable
    output logic             irq_req     // Combined request
);
    // Only live bits may unmask; reserved bits never do
    always_comb begin
        irq_req = global_en && |(status & enable & hcie_pkg::MASK_LIVE);
    end
endmodule

// *** hcie_pkg.sv ***
// Package for the host-side processor interrupt enable and identifier block.
// Assumes a 16-bit shared processor bus that carries command codes then data.
package hcie_pkg;

    // ==========================================================
    // Command codes
    localparam logic [7:0]  CMD_MASK_RD      = 8'h25;  // Read enable mask
    localparam logic [7:0]  CMD_MASK_WR      = 8'ha5;  // Write enable mask
    localparam logic [7:0]  CMD_ID_RD        = 8'h27;  // Read identifier

    // ==========================================================
    // Enable field positions
    localparam int          BIT_SOF          = 0;      // Frame start
    localparam int          BIT_ASYNC        = 1;      // Async list
    localparam int          BIT_EOT          = 2;      // End of transfer
    localparam int          BIT_OPR          = 4;      // Operational reg event
    localparam int          BIT_SUSP         = 5;      // Host suspended
    localparam int          BIT_CLKRDY       = 6;      // Clock ready
    localparam logic [15:0] MASK_LIVE        = 16'h0077; // Bits that gate sources
    localparam logic [15:0] MASK_RESET       = 16'h0000; // Power-on mask
    localparam int          HW_GLOBAL_BIT    = 0;      // Global enable in hw config

    // ==========================================================
    // Identifier layout; both values arbitrary, not a real part's
    localparam logic [7:0]  ID_PRODUCT       = 8'h5a;  // Arbitrary product code
    localparam logic [7:0]  ID_REVISION      = 8'h01;  // Arbitrary revision
    localparam logic [15:0] DATA_ZERO        = 16'h0000; // Idle read data

    // ==========================================================
    // Bus transaction states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,   // Waiting for a command
        ST_WDAT = 3'b010,   // Waiting for write data
        ST_RDAT = 3'b100    // Presenting read data
    } hcie_state_t;

endpackage

// *** hcie_sync.sv ***
// Two-flop synchroniser for one pin-level input.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/100ps
module hcie_sync (
    input  wire logic clk_sys,   // System clock
    input  wire logic rst,       // Sync reset, high
    input  wire logic d_in,      // Async level
    output logic      q_out      // Synchronised level
);
    // ==========================================================
    // Synchroniser flops
    logic meta_r;                // First stage, read only by q_out

    // Two stages
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_r <= 1'b0;
            q_out  <= 1'b0;
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule

// *** hcie_top.sv ***
// Processor interrupt enable mask and identifier register of the host side.
// Assumes a shared 16-bit bus: command cycle (cmd_wr_n) then data cycle.
// Status events and the global enable come from logic on clk_sys.
`timescale 1ns/100ps

module hcie_top (
    input  wire logic        clk_sys,      // System clock 25 MHz
    input  wire logic        rst,          // Sync reset, high
    input  wire logic        cs_n,         // Chip select pin, low
    input  wire logic        cmd_wr_n,     // Command strobe pin, low
    input  wire logic        wr_n,         // Data write strobe pin, low
    input  wire logic        rd_n,         // Data read strobe pin, low
    input  wire logic [15:0] data_in,      // Bus data in
    output logic      [15:0] data_out,     // Bus data out
    output logic             data_oe_n,    // Bus drive enable, low drives
    input  wire logic [15:0] host_cpu_irq_status, // Status bits
    input  wire logic        host_hw_config_en,   // Global enable bit
    input  wire logic        suspend_req,  // Control register wrote suspend
    input  wire logic        downstream_suspended, // All ports suspended
    output logic             sof_enable,   // Frame generator running
    output logic             host_irq_pin  // Interrupt request, high
);
    // ==========================================================
    // Pin synchronisers
    logic cs_s;        // Synchronised select (active high level)
    logic cmd_s;       // Synchronised command strobe
    logic wr_s;        // Synchronised write strobe
    logic rd_s;        // Synchronised read strobe
    logic [15:0] din_s1_r; // Data first stage
    logic [15:0] din_s2_r; // Data second stage

    hcie_sync u_cs  (.clk_sys(clk_sys), .rst(rst), .d_in(~cs_n),     .q_out(cs_s));
    hcie_sync u_cmd (.clk_sys(clk_sys), .rst(rst), .d_in(~cmd_wr_n), .q_out(cmd_s));
    hcie_sync u_wr  (.clk_sys(clk_sys), .rst(rst), .d_in(~wr_n),     .q_out(wr_s));
    hcie_sync u_rd  (.clk_sys(clk_sys), .rst(rst), .d_in(~rd_n),     .q_out(rd_s));

    // Data bus two-flop stage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            din_s1_r <= hcie_pkg::DATA_ZERO;
            din_s2_r <= hcie_pkg::DATA_ZERO;
        end else begin
            din_s1_r <= data_in;
            din_s2_r <= din_s1_r;
        end
    end

    // ==========================================================
    // Strobe edge detection on synchronised levels
    logic cmd_d_r;     // Previous command strobe
    logic wr_d_r;      // Previous write strobe
    logic rd_d_r;      // Previous read strobe
    logic cmd_rise;    // Command strobe asserted
    logic wr_rise;     // Write strobe asserted
    logic rd_rise;     // Read strobe asserted
    logic rd_fall;     // Read strobe released

    // Delay strobes one cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmd_d_r <= 1'b0;
            wr_d_r  <= 1'b0;
            rd_d_r  <= 1'b0;
        end else begin
            cmd_d_r <= cmd_s;
            wr_d_r  <= wr_s;
            rd_d_r  <= rd_s;
        end
    end

    assign cmd_rise = cs_s && cmd_s && !cmd_d_r;
    assign wr_rise  = cs_s && wr_s && !wr_d_r;
    assign rd_rise  = cs_s && rd_s && !rd_d_r;
    assign rd_fall  = !rd_s && rd_d_r;

    // ==========================================================
    // Command decoder
    hcie_pkg::hcie_state_t state_r;   // Bus state
    hcie_pkg::hcie_state_t state_nxt; // Next bus state
    logic [7:0]  cmd_r;               // Latched command code
    logic [15:0] mask_r;              // Enable mask register

    // Next-state logic
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            hcie_pkg::ST_IDLE: begin
                // Only known codes open a data phase
                if (cmd_rise && din_s2_r[7:0] == hcie_pkg::CMD_MASK_WR) begin
                    state_nxt = hcie_pkg::ST_WDAT;
                end else if (cmd_rise && (din_s2_r[7:0] == hcie_pkg::CMD_MASK_RD ||
                                          din_s2_r[7:0] == hcie_pkg::CMD_ID_RD)) begin
                    state_nxt = hcie_pkg::ST_RDAT;
                end
            end
            hcie_pkg::ST_WDAT: begin
                // Write data taken on strobe
                if (wr_rise || cmd_rise) begin
                    state_nxt = hcie_pkg::ST_IDLE;
                end
            end
            hcie_pkg::ST_RDAT: begin
                // Read finished on strobe release
                if (rd_fall || cmd_rise) begin
                    state_nxt = hcie_pkg::ST_IDLE;
                end
            end
            default: state_nxt = hcie_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r <= hcie_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Latch command code
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmd_r <= 8'h00;
        end else if (cmd_rise) begin
            cmd_r <= din_s2_r[7:0];
        end
    end

    // ==========================================================
    // Enable mask register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mask_r <= hcie_pkg::MASK_RESET;
        end else if (state_r == hcie_pkg::ST_WDAT && wr_rise) begin
            mask_r <= din_s2_r;
        end
    end

    // ==========================================================
    // Read data path
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_out  <= hcie_pkg::DATA_ZERO;
            data_oe_n <= 1'b1;
        end else if (state_r == hcie_pkg::ST_RDAT && rd_rise) begin
            data_oe_n <= 1'b0;
            if (cmd_r == hcie_pkg::CMD_ID_RD) begin
                data_out <= {hcie_pkg::ID_PRODUCT, hcie_pkg::ID_REVISION};
            end else begin
                data_out <= mask_r;
            end
        end else if (state_r != hcie_pkg::ST_RDAT || rd_fall) begin
            data_out  <= hcie_pkg::DATA_ZERO;
            data_oe_n <= 1'b1;
        end
    end

    // ==========================================================
    // Suspend sequencing
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sof_enable <= 1'b1;
        end else if (suspend_req && downstream_suspended) begin
            sof_enable <= 1'b0;
        end else if (!suspend_req) begin
            sof_enable <= 1'b1;
        end
    end

    // ==========================================================
    // Interrupt output
    logic irq_req; // Combined gated request

    // end of transfer through bit 2
    hcie_gate u_gate (
        .status    (host_cpu_irq_status),
        .enable    (mask_r),
        .global_en (host_hw_config_en),
        .irq_req   (irq_req)
    );

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            host_irq_pin <= 1'b0;
        end else begin
            host_irq_pin <= irq_req;
        end
    end

    // ==========================================================
    // Assertions
    a_reset_masked: assert property (@(posedge clk_sys)
        !rst && $past(rst) |-> mask_r == hcie_pkg::MASK_RESET && !host_irq_pin)
        else $error("Mask or irq not clear after reset");

    a_irq_follows: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 host_irq_pin == $past(host_hw_config_en &&
            |(host_cpu_irq_status & mask_r & hcie_pkg::MASK_LIVE)))
        else $error("Interrupt pin does not follow gated status");

    a_global_blocks: assert property (@(posedge clk_sys) disable iff (rst)
        !host_hw_config_en |=> !host_irq_pin)
        else $error("Interrupt raised without global enable");

    a_clkrdy_pass: assert property (@(posedge clk_sys) disable iff (rst)
        host_hw_config_en && mask_r[hcie_pkg::BIT_CLKRDY] &&
        host_cpu_irq_status[hcie_pkg::BIT_CLKRDY] |=> host_irq_pin)
        else $error("Clock-ready event not passed");

    a_susp_pass: assert property (@(posedge clk_sys) disable iff (rst)
        host_hw_config_en && mask_r[hcie_pkg::BIT_SUSP] &&
        host_cpu_irq_status[hcie_pkg::BIT_SUSP] |=> host_irq_pin)
        else $error("Suspend event not passed");

    a_opr_pass: assert property (@(posedge clk_sys) disable iff (rst)
        host_hw_config_en && mask_r[hcie_pkg::BIT_OPR] &&
        host_cpu_irq_status[hcie_pkg::BIT_OPR] |=> host_irq_pin)
        else $error("Operational event not passed");

    a_eot_pass: assert property (@(posedge clk_sys) disable iff (rst)
        host_hw_config_en && mask_r[hcie_pkg::BIT_EOT] &&
        host_cpu_irq_status[hcie_pkg::BIT_EOT] |=> host_irq_pin)
        else $error("End-of-transfer event not passed");

    a_async_pass: assert property (@(posedge clk_sys) disable iff (rst)
        host_hw_config_en && mask_r[hcie_pkg::BIT_ASYNC] &&
        host_cpu_irq_status[hcie_pkg::BIT_ASYNC] |=> host_irq_pin)
        else $error("Async list event not passed");

    a_sof_pass: assert property (@(posedge clk_sys) disable iff (rst)
        host_hw_config_en && mask_r[hcie_pkg::BIT_SOF] &&
        host_cpu_irq_status[hcie_pkg::BIT_SOF] |=> host_irq_pin)
        else $error("Frame-start event not passed");

    a_reserved_mute: assert property (@(posedge clk_sys) disable iff (rst)
        (host_cpu_irq_status & mask_r & hcie_pkg::MASK_LIVE) == 16'h0000 |=> !host_irq_pin)
        else $error("Reserved bit unmasked a source");

    a_masked_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        (mask_r & hcie_pkg::MASK_LIVE) == 16'h0000 |=> !host_irq_pin)
        else $error("Masked source raised interrupt");

    sequence s_mask_write;
        state_r == hcie_pkg::ST_WDAT && wr_rise;
    endsequence
    a_mask_write: assert property (@(posedge clk_sys) disable iff (rst)
        s_mask_write |=> mask_r == $past(din_s2_r))
        else $error("Mask write not stored");

    sequence s_id_read;
        state_r == hcie_pkg::ST_RDAT && rd_rise && cmd_r == hcie_pkg::CMD_ID_RD;
    endsequence
    a_id_read: assert property (@(posedge clk_sys) disable iff (rst)
        s_id_read |=> !data_oe_n && data_out == {hcie_pkg::ID_PRODUCT, hcie_pkg::ID_REVISION})
        else $error("Identifier not returned");

    a_id_fixed: assert property (@(posedge clk_sys) disable iff (rst)
        state_r == hcie_pkg::ST_WDAT |-> cmd_r != hcie_pkg::CMD_ID_RD)
        else $error("Identifier accepted a write");

    a_sof_stop: assert property (@(posedge clk_sys) disable iff (rst)
        suspend_req && downstream_suspended |=> !sof_enable)
        else $error("Frames not stopped on suspend");

    // Mask read returns the stored word
    sequence s_mask_read;
        state_r == hcie_pkg::ST_RDAT && rd_rise && cmd_r == hcie_pkg::CMD_MASK_RD;
    endsequence
    a_mask_read: assert property (@(posedge clk_sys) disable iff (rst)
        s_mask_read |=> !data_oe_n && data_out == $past(mask_r))
        else $error("Mask read returned wrong word");

    // Bus released once the read strobe goes away
    a_read_release: assert property (@(posedge clk_sys) disable iff (rst)
        rd_fall |=> data_oe_n && data_out == hcie_pkg::DATA_ZERO)
        else $error("Read data not released");
endmodule

// *** tb_host_cpu_irq_enable_and_id.sv ***
// Self-checking bench: mask and identifier access, source gating, suspend.
// Assumes hcie_top and hcie_cpu_model; processor traffic goes through the model.
`timescale 1ns/100ps
module tb_host_cpu_irq_enable_and_id;
    logic        clk_sys;      // System clock
    logic        rst;          // Sync reset
    logic        cs_n;         // Bus lines from processor model
    logic        cmd_wr_n;
    logic        wr_n;
    logic        rd_n;
    logic [15:0] data_in;
    logic [15:0] data_out;     // Block read data
    logic        data_oe_n;    // Block drive enable
    logic [15:0] status;       // Pending events
    logic        glob;         // Global enable
    logic        suspend_req;  // Suspend asked
    logic        down_susp;    // Ports suspended
    logic        sof_enable;   // Frame generator running
    logic        irq_pin;      // Interrupt output
    logic        cpu_timeout;  // Missing read answer
    logic [15:0] rd_val;       // Last read word
    int          err_count;    // Mismatches
    int          compares;     // Comparisons
    int          mask_m;       // Model of the mask register
    int          st_m;         // Model of status
    int          g_m;          // Model of global enable
    int          rd_q[$];      // Expected read words, oldest first

    // ==========================================================
    // Clock and instances
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    hcie_top u_dut (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .cmd_wr_n(cmd_wr_n), .wr_n(wr_n),
        .rd_n(rd_n), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
        .host_cpu_irq_status(status), .host_hw_config_en(glob), .suspend_req(suspend_req),
        .downstream_suspended(down_susp), .sof_enable(sof_enable), .host_irq_pin(irq_pin));

    hcie_cpu_model u_cpu (.clk_sys(clk_sys), .data_out(data_out), .data_oe_n(data_oe_n), .cs_n(cs_n),
        .cmd_wr_n(cmd_wr_n), .wr_n(wr_n), .rd_n(rd_n), .data_in(data_in), .timeout(cpu_timeout));

    // ==========================================================
    // Model, comparison and closing
    function automatic logic exp_irq();
        return (g_m != 0) && ((st_m & mask_m & int'(hcie_pkg::MASK_LIVE)) != 0);
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Drive status and global, let the registered output land
    task automatic drive_src(input int st, input int g);
        @(posedge clk_sys);
        status <= st[15:0];
        glob   <= g[0];
        st_m = st & 32'h0000ffff;
        g_m = g & 1;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic set_mask(input int v);
        u_cpu.write_reg(hcie_pkg::CMD_MASK_WR, v[15:0]);
        mask_m = v & 32'h0000ffff;
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic report_and_stop();
        $display("Counts: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog on the whole run
    initial begin
        #400000;
        err_count++;
        report_and_stop();
    end

    // ==========================================================
    // Test sequence
    initial begin
        rst = 1'b1;
        status = 16'h0000;
        glob = 1'b0;
        suspend_req = 1'b0;
        down_susp = 1'b0;
        err_count = 0;
        compares = 0;
        mask_m = 0;
        void'($urandom(32'h85d081bf));
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset: every source pending yet nothing raised
        drive_src(32'hffff, 1);
        check("irq_after_reset", {15'h0000, irq_pin}, 16'h0000);
        check("sof_after_reset", {15'h0000, sof_enable}, 16'h0001);
        u_cpu.read_reg(hcie_pkg::CMD_MASK_RD, rd_val);
        check("mask_reset", rd_val, hcie_pkg::MASK_RESET);
        $display("TEST reset done");
        // Identifier; no write code, unknown codes ignored
        u_cpu.read_reg(hcie_pkg::CMD_ID_RD, rd_val);
        check("identifier", rd_val, {hcie_pkg::ID_PRODUCT, hcie_pkg::ID_REVISION});
        u_cpu.write_reg(8'ha7, 16'(~{hcie_pkg::ID_PRODUCT, hcie_pkg::ID_REVISION}));
        u_cpu.write_reg(8'h33, 16'hffff);
        u_cpu.read_reg(hcie_pkg::CMD_ID_RD, rd_val);
        check("identifier_ro", rd_val, {hcie_pkg::ID_PRODUCT, hcie_pkg::ID_REVISION});
        u_cpu.read_reg(hcie_pkg::CMD_MASK_RD, rd_val);
        check("mask_untouched", rd_val, mask_m[15:0]);
        $display("TEST identifier done");
        // Mask write and read back, reserved bits kept
        for (int i = 0; i < 6; i++) begin
            set_mask($urandom & 32'h0000ffff);
            rd_q.push_back(mask_m);
            u_cpu.read_reg(hcie_pkg::CMD_MASK_RD, rd_val);
            check("mask_rw", rd_val, 16'(rd_q.pop_front()));
        end
        $display("TEST mask access done");
        // One enable per source, every bit position
        for (int b = 0; b < 16; b++) begin
            set_mask(1 << b);
            drive_src(1 << b, 1);
            check("irq_own_bit", {15'h0000, irq_pin}, {15'h0000, exp_irq()});
            drive_src(~(1 << b), 1);
            check("irq_other_bits", {15'h0000, irq_pin}, {15'h0000, exp_irq()});
            drive_src(1 << b, 0);
            check("irq_global_off", {15'h0000, irq_pin}, 16'h0000);
        end
        $display("TEST per source gating done");
        // Random status, mask and global
        for (int i = 0; i < 8; i++) begin
            set_mask($urandom & 32'h0000ffff);
            drive_src($urandom, $urandom);
            check("irq_random", {15'h0000, irq_pin}, {15'h0000, exp_irq()});
        end
        $display("TEST random gating done");
        // Mid-run reset clears the mask again
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        mask_m = 0;
        u_cpu.read_reg(hcie_pkg::CMD_MASK_RD, rd_val);
        check("mask_rereset", rd_val, mask_m[15:0]);
        check("irq_rereset", {15'h0000, irq_pin}, {15'h0000, exp_irq()});
        $display("TEST mid-run reset done");
        @(posedge clk_sys);
        suspend_req <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        check("sof_ports_awake", {15'h0000, sof_enable}, 16'h0001);
        @(posedge clk_sys);
        down_susp <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        check("sof_suspended", {15'h0000, sof_enable}, 16'h0000);
        @(posedge clk_sys);
        suspend_req <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        check("sof_resumed", {15'h0000, sof_enable}, 16'h0001);
        $display("TEST suspend done");
        check("read_answered", {15'h0000, cpu_timeout}, 16'h0000);
        report_and_stop();
    end
endmodule
